// ===== src/sfrdc_map.svh
// offsets, page codes and reset values of the register space
`ifndef SFRDC_MAP_SVH
`define SFRDC_MAP_SVH

// ***********************************************************
// space limits and page codes
// ***********************************************************
`define SFRDC_SPACE_BIT 7
`define SFRDC_BITSEL_LSB 3
`define SFRDC_PAGE_BASE 8'h00
`define SFRDC_PAGE_ALT 8'h0F

// ***********************************************************
// byte offsets
// ***********************************************************
`define SFRDC_A_PORT1_LATCH 8'h90
`define SFRDC_A_CMP1_SEL 8'h9E
`define SFRDC_A_PORT2_LATCH 8'hA0
`define SFRDC_A_PORT0_OMODE 8'hA4
`define SFRDC_A_PORT1_DRV_OMODE 8'hA5
`define SFRDC_A_PORT2_DRV_OMODE 8'hA6
`define SFRDC_A_PAGE_SELECT 8'hA7
`define SFRDC_A_ADC_CHANNEL 8'hBB
`define SFRDC_A_PORT1_MMASK 8'hBF
`define SFRDC_A_CA_MOD5_MODE 8'hCE
`define SFRDC_A_PORT1_MVALUE 8'hCF
`define SFRDC_A_CA_CAP5_LO 8'hD2
`define SFRDC_A_CA_CAP5_HI 8'hD3
`define SFRDC_A_PORT0_BYPASS 8'hD4
`define SFRDC_A_PORT1_BYPASS 8'hD5
`define SFRDC_A_CA_CONTROL 8'hD8
`define SFRDC_A_CA_MOD0_MODE 8'hDA
`define SFRDC_A_CA_MOD1_MODE 8'hDB
`define SFRDC_A_CA_MOD2_MODE 8'hDC
`define SFRDC_A_CA_MOD3_MODE 8'hDD
`define SFRDC_A_CA_MOD4_MODE 8'hDE
`define SFRDC_A_CA_CAP1_LO 8'hE9
`define SFRDC_A_CA_CAP1_HI 8'hEA
`define SFRDC_A_CA_CAP2_LO 8'hEB
`define SFRDC_A_CA_CAP2_HI 8'hEC
`define SFRDC_A_CA_CAP3_LO 8'hED
`define SFRDC_A_CA_CAP3_HI 8'hEE
`define SFRDC_A_PORT1_IMODE 8'hF2
`define SFRDC_A_CA_COUNT_LO 8'hF9
`define SFRDC_A_CA_COUNT_HI 8'hFA
`define SFRDC_A_CA_CAP0_LO 8'hFB
`define SFRDC_A_CA_CAP0_HI 8'hFC
`define SFRDC_A_CA_CAP4_LO 8'hFD
`define SFRDC_A_CA_CAP4_HI 8'hFE

// ***********************************************************
// reset values and field positions
// ***********************************************************
`define SFRDC_RST_DEFAULT 8'h00
`define SFRDC_RST_CMP1_SEL 8'hFF
`define SFRDC_RST_PAGE 8'h00
`define SFRDC_CMP_NEG_MSB 7
`define SFRDC_CMP_NEG_LSB 4
`define SFRDC_CMP_POS_MSB 3
`define SFRDC_CMP_POS_LSB 0

`endif

// ===== src/sfrdc_pkg.sv
// types shared by the register space and the comparator select decoder
package sfrdc_pkg;

  typedef enum logic [5:0] {
    R_PORT1_LATCH, R_CMP1_SEL, R_PORT2_LATCH, R_PORT0_OMODE,
    R_PORT1_DRV, R_PORT1_OMODE, R_PORT2_DRV, R_PORT2_OMODE,
    R_PAGE, R_ADC_CHANNEL, R_PORT1_MMASK, R_CA_MOD5_MODE,
    R_PORT1_MVALUE, R_CA_CAP5_LO, R_CA_CAP5_HI, R_PORT0_BYPASS,
    R_PORT1_BYPASS, R_CA_CONTROL, R_CA_MOD0_MODE, R_CA_MOD1_MODE,
    R_CA_MOD2_MODE, R_CA_MOD3_MODE, R_CA_MOD4_MODE, R_CA_CAP1_LO,
    R_CA_CAP1_HI, R_CA_CAP2_LO, R_CA_CAP2_HI, R_CA_CAP3_LO,
    R_CA_CAP3_HI, R_PORT1_IMODE, R_CA_COUNT_LO, R_CA_COUNT_HI,
    R_CA_CAP0_LO, R_CA_CAP0_HI, R_CA_CAP4_LO, R_CA_CAP4_HI,
    R_COUNT
  } sfrdc_reg_t;

  localparam int SFRDC_NREG = int'(R_COUNT);

  typedef enum logic [2:0] {
    SRC_PIN = 3'b000,
    SRC_TOUCH = 3'b001,
    SRC_HALF_SUPPLY = 3'b010,
    SRC_DIG_SUPPLY = 3'b011,
    SRC_GROUND = 3'b100,
    SRC_BAT_SUPPLY = 3'b101,
    SRC_MAIN_SUPPLY = 3'b110,
    SRC_RESERVED = 3'b111
  } sfrdc_src_t;

  typedef struct packed {
    logic valid;
    sfrdc_src_t src;
    logic pin_port;
    logic [2:0] pin_bit;
  } sfrdc_cmp_sel_t;

  typedef struct packed {
    logic rd;
    logic wr;
    logic bit_op;
    logic [7:0] addr;
    logic [7:0] wdata;
    logic bit_val;
  } sfrdc_req_t;

  typedef struct packed {
    logic rvalid;
    logic [7:0] rdata;
    logic ram_access;
    logic unmapped;
  } sfrdc_rsp_t;

  typedef struct packed {
    logic hit;
    sfrdc_reg_t idx;
  } sfrdc_dec_t;

endpackage : sfrdc_pkg

// ===== src/sfrdc_cmp_decode.sv
// decoder of one comparator input select field
`timescale 1ns/1ps
module sfrdc_cmp_decode
  import sfrdc_pkg::*;
#(
  parameter bit NEGATIVE = 1'b1
) (
  input wire logic [3:0] code,
  output sfrdc_cmp_sel_t sel
);

  always_comb begin
    sel = '0;
    sel.valid = 1'b1;
    sel.src = SRC_PIN;
    // ***********************************************************
    // code table
    // ***********************************************************
    if (!code[3]) begin
      // negative pins are odd bits, top code reserved
      sel.pin_port = code[2];
      sel.pin_bit = {code[1:0], NEGATIVE};
      if (NEGATIVE && code[2:0] == 3'h7) begin
        // reserved code leaves the input undefined
        sel = '0;
        sel.src = SRC_RESERVED;
      end
    end else begin
      case (code[2:0])
        3'h4: sel.src = SRC_TOUCH;
        3'h5: sel.src = SRC_HALF_SUPPLY;
        3'h6: sel.src = NEGATIVE ? SRC_DIG_SUPPLY : SRC_BAT_SUPPLY;
        3'h7: sel.src = NEGATIVE ? SRC_GROUND : SRC_MAIN_SUPPLY;
        default: begin
          // codes 8 to B select nothing defined
          sel.valid = 1'b0;
          sel.src = SRC_RESERVED;
        end
      endcase
    end
  end

endmodule : sfrdc_cmp_decode

// ===== src/sfrdc_top.sv
// special-function register space with page decode and comparator select
// Operation
// - Direct accesses at 0x80 to 0xFF reach this space, not RAM.
// - Only registers at offsets ending 0x0 or 0x8 take bit access.
// - Offset 0xA5 is drive strength on page 0xF, output mode on 0x0.
// - Negative field 7:4 picks odd pins, touch, half, digital, ground.
// - Positive field 3:0 picks even pins, touch, half, battery, main.
// - The ADC mux takes its positive input from its channel select.
`timescale 1ns/1ps
`include "sfrdc_map.svh"
module sfrdc_top
  import sfrdc_pkg::*;
#(
  parameter int DATA_W = 8
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic ce,
  input sfrdc_req_t req,
  output sfrdc_rsp_t rsp,
  output sfrdc_cmp_sel_t cmp1_negative_select,
  output sfrdc_cmp_sel_t cmp1_positive_select,
  output logic [7:0] adc_channel_select,
  output logic [7:0] register_page_select
);

  // ***********************************************************
  // parameter check
  // ***********************************************************
  generate
    if (DATA_W != 8) begin : g_bad_width
      $error("sfrdc_top serves 8-bit registers only");
    end
  endgenerate

  typedef struct packed {
    logic [SFRDC_NREG-1:0][7:0] regs;
    sfrdc_rsp_t rsp;
    sfrdc_cmp_sel_t neg;
    sfrdc_cmp_sel_t pos;
    logic [7:0] adc;
  } sfrdc_state_t;

  sfrdc_state_t st;
  sfrdc_state_t next_st;
  sfrdc_cmp_sel_t neg_dec;
  sfrdc_cmp_sel_t pos_dec;

  // ***********************************************************
  // address decode
  // ***********************************************************
  function automatic sfrdc_dec_t sfr_decode(
    input logic [7:0] a,
    input logic [7:0] pg
  );
    sfrdc_dec_t d;
    logic any_page;
    d.hit = 1'b1;
    d.idx = R_PORT1_LATCH;
    any_page = 1'b0;
    case (a)
      `SFRDC_A_PORT1_LATCH: begin
        d.idx = R_PORT1_LATCH;
        any_page = 1'b1;
      end
      `SFRDC_A_PORT2_LATCH: begin
        d.idx = R_PORT2_LATCH;
        any_page = 1'b1;
      end
      `SFRDC_A_PAGE_SELECT: begin
        d.idx = R_PAGE;
        any_page = 1'b1;
      end
      `SFRDC_A_PORT1_DRV_OMODE: begin
        d.idx = (pg == `SFRDC_PAGE_ALT) ? R_PORT1_DRV : R_PORT1_OMODE;
        any_page = (pg == `SFRDC_PAGE_ALT);
      end
      `SFRDC_A_PORT2_DRV_OMODE: begin
        d.idx = (pg == `SFRDC_PAGE_ALT) ? R_PORT2_DRV : R_PORT2_OMODE;
        any_page = (pg == `SFRDC_PAGE_ALT);
      end
      `SFRDC_A_CMP1_SEL: d.idx = R_CMP1_SEL;
      `SFRDC_A_PORT0_OMODE: d.idx = R_PORT0_OMODE;
      `SFRDC_A_ADC_CHANNEL: d.idx = R_ADC_CHANNEL;
      `SFRDC_A_PORT1_MMASK: d.idx = R_PORT1_MMASK;
      `SFRDC_A_CA_MOD5_MODE: d.idx = R_CA_MOD5_MODE;
      `SFRDC_A_PORT1_MVALUE: d.idx = R_PORT1_MVALUE;
      `SFRDC_A_CA_CAP5_LO: d.idx = R_CA_CAP5_LO;
      `SFRDC_A_CA_CAP5_HI: d.idx = R_CA_CAP5_HI;
      `SFRDC_A_PORT0_BYPASS: d.idx = R_PORT0_BYPASS;
      `SFRDC_A_PORT1_BYPASS: d.idx = R_PORT1_BYPASS;
      `SFRDC_A_CA_CONTROL: d.idx = R_CA_CONTROL;
      `SFRDC_A_CA_MOD0_MODE: d.idx = R_CA_MOD0_MODE;
      `SFRDC_A_CA_MOD1_MODE: d.idx = R_CA_MOD1_MODE;
      `SFRDC_A_CA_MOD2_MODE: d.idx = R_CA_MOD2_MODE;
      `SFRDC_A_CA_MOD3_MODE: d.idx = R_CA_MOD3_MODE;
      `SFRDC_A_CA_MOD4_MODE: d.idx = R_CA_MOD4_MODE;
      `SFRDC_A_CA_CAP1_LO: d.idx = R_CA_CAP1_LO;
      `SFRDC_A_CA_CAP1_HI: d.idx = R_CA_CAP1_HI;
      `SFRDC_A_CA_CAP2_LO: d.idx = R_CA_CAP2_LO;
      `SFRDC_A_CA_CAP2_HI: d.idx = R_CA_CAP2_HI;
      `SFRDC_A_CA_CAP3_LO: d.idx = R_CA_CAP3_LO;
      `SFRDC_A_CA_CAP3_HI: d.idx = R_CA_CAP3_HI;
      `SFRDC_A_PORT1_IMODE: d.idx = R_PORT1_IMODE;
      `SFRDC_A_CA_COUNT_LO: d.idx = R_CA_COUNT_LO;
      `SFRDC_A_CA_COUNT_HI: d.idx = R_CA_COUNT_HI;
      `SFRDC_A_CA_CAP0_LO: d.idx = R_CA_CAP0_LO;
      `SFRDC_A_CA_CAP0_HI: d.idx = R_CA_CAP0_HI;
      `SFRDC_A_CA_CAP4_LO: d.idx = R_CA_CAP4_LO;
      `SFRDC_A_CA_CAP4_HI: d.idx = R_CA_CAP4_HI;
      default: d.hit = 1'b0;
    endcase
    // page-0 registers vanish while another page is selected
    if (!any_page && pg != `SFRDC_PAGE_BASE) begin
      d.hit = 1'b0;
    end
    return d;
  endfunction : sfr_decode

  // ***********************************************************
  // comparator field decoders
  // ***********************************************************
  sfrdc_cmp_decode #(
    .NEGATIVE(1'b1)
  ) u_neg_decode (
    .code(st.regs[R_CMP1_SEL][`SFRDC_CMP_NEG_MSB:`SFRDC_CMP_NEG_LSB]),
    .sel(neg_dec)
  );

  sfrdc_cmp_decode #(
    .NEGATIVE(1'b0)
  ) u_pos_decode (
    .code(st.regs[R_CMP1_SEL][`SFRDC_CMP_POS_MSB:`SFRDC_CMP_POS_LSB]),
    .sel(pos_dec)
  );

  // ***********************************************************
  // access handling
  // ***********************************************************
  always_comb begin
    logic [7:0] byte_addr;
    logic [7:0] cur;
    sfrdc_dec_t dec;
    byte_addr = '0;
    cur = '0;
    dec = '0;
    next_st = st;
    next_st.rsp = '0;
    // decoded selects follow the stored field, reserved or not
    next_st.neg = neg_dec;
    next_st.pos = pos_dec;
    // ADC positive input follows its channel select
    next_st.adc = st.regs[R_ADC_CHANNEL];
    if (req.rd || req.wr) begin
      // a bit address always lands on an offset ending 0 or 8
      byte_addr = req.bit_op ?
        {req.addr[7:`SFRDC_BITSEL_LSB], 3'h0} : req.addr;
      // the upper half of direct space is this register space
      if (!byte_addr[`SFRDC_SPACE_BIT]) begin
        next_st.rsp.ram_access = 1'b1;
      end else begin
        dec = sfr_decode(byte_addr, st.regs[R_PAGE]);
        if (!dec.hit) begin
          // unassigned offsets read as zero and swallow writes
          next_st.rsp.unmapped = 1'b1;
          next_st.rsp.rvalid = req.rd;
        end else begin
          cur = st.regs[dec.idx];
          next_st.rsp.rvalid = req.rd;
          // read returns the value held before a same-cycle write
          next_st.rsp.rdata = req.bit_op ?
            {7'h00, cur[req.addr[2:0]]} : cur;
          if (req.wr) begin
            if (req.bit_op) begin
              // bit write touches one bit only
              cur[req.addr[2:0]] = req.bit_val;
            end else begin
              cur = req.wdata;
            end
            next_st.regs[dec.idx] = cur;
          end
        end
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      for (int i = 0; i < SFRDC_NREG; i++) begin
        st.regs[i] <= `SFRDC_RST_DEFAULT;
      end
      st.regs[R_CMP1_SEL] <= `SFRDC_RST_CMP1_SEL;
      st.regs[R_PAGE] <= `SFRDC_RST_PAGE;
      st.rsp <= '0;
      st.neg <= '0;
      st.pos <= '0;
      st.adc <= `SFRDC_RST_DEFAULT;
    end else if (ce) begin
      st <= next_st;
    end
  end

  assign rsp = st.rsp;
  assign cmp1_negative_select = st.neg;
  assign cmp1_positive_select = st.pos;
  assign adc_channel_select = st.adc;
  assign register_page_select = st.regs[R_PAGE];

endmodule : sfrdc_top

// ===== testbench/sfrdc_checker.sv
// port-level assertions for the register space
`timescale 1ns/1ps
module sfrdc_checker
  import sfrdc_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic ce,
  input sfrdc_req_t req,
  input sfrdc_rsp_t rsp,
  input sfrdc_cmp_sel_t cmp1_negative_select,
  input sfrdc_cmp_sel_t cmp1_positive_select,
  input wire logic [7:0] adc_channel_select,
  input wire logic [7:0] register_page_select
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  logic rd_byte;
  logic cmp_wr;
  assign rd_byte = ce && req.rd && !req.wr && !req.bit_op;
  // only page 0 reaches the comparator select register
  assign cmp_wr = ce && req.wr && !req.rd && !req.bit_op
    && req.addr == 8'h9E && register_page_select == 8'h00;

  ram_route_a: assert property (
    ce && (req.rd || req.wr) && !req.addr[7]
    |=> rsp.ram_access && !rsp.rvalid)
    else $error("low access not to ram");
  sfr_route_a: assert property (
    ce && req.rd && !req.wr && req.addr[7]
    |=> rsp.rvalid && !rsp.ram_access)
    else $error("high read not answered");
  write_quiet_a: assert property (
    ce && req.wr && !req.rd
    |=> !rsp.rvalid)
    else $error("write gave read data");
  bit_read_a: assert property (
    ce && req.rd && !req.wr && req.bit_op
    |=> rsp.rdata[7:1] == 7'h00)
    else $error("bit read wider than a bit");
  page_read_a: assert property (
    rd_byte && req.addr == 8'hA7
    |=> rsp.rdata == $past(register_page_select))
    else $error("page read");
  alt_page_a: assert property (
    rd_byte && req.addr == 8'hA5 && register_page_select == 8'h0F
    |=> !rsp.unmapped)
    else $error("drive strength not mapped");
  other_page_a: assert property (
    rd_byte && req.addr == 8'hA5
    && !(register_page_select inside {8'h00, 8'h0F})
    |=> rsp.unmapped && rsp.rdata == 8'h00)
    else $error("foreign page hit");
  neg_ground_a: assert property (
    cmp_wr && req.wdata[7:4] == 4'hF ##1 ce [*3]
    |-> cmp1_negative_select.valid
    && cmp1_negative_select.src == SRC_GROUND)
    else $error("neg not ground");
  pos_reserved_a: assert property (
    cmp_wr && req.wdata[3:2] == 2'b10 ##1 ce [*3]
    |-> !cmp1_positive_select.valid
    && cmp1_positive_select.src == SRC_RESERVED)
    else $error("pos reserved");
  neg_reserved_a: assert property (
    cmp_wr && req.wdata[7:4] == 4'h7 ##1 ce [*3]
    |-> !cmp1_negative_select.valid
    && cmp1_negative_select.src == SRC_RESERVED)
    else $error("neg reserved");

  cover property (cmp_wr);
  cover property (rd_byte && req.addr == 8'hA5
    && register_page_select == 8'h0F);
  cover property (ce && req.wr && req.bit_op);
  cover property (!ce && (req.rd || req.wr));
endmodule : sfrdc_checker

bind sfrdc_top sfrdc_checker chk_u (.ref_clk(ref_clk), .rst_n(rst_n),
  .ce(ce), .req(req), .rsp(rsp),
  .cmp1_negative_select(cmp1_negative_select),
  .cmp1_positive_select(cmp1_positive_select),
  .adc_channel_select(adc_channel_select),
  .register_page_select(register_page_select));

// ===== testbench/sfrdc_tb_top.sv
// self-checking bench for the register space
`timescale 1ns/1ps
module sfrdc_tb_top
  import sfrdc_pkg::*;
;
  logic ref_clk;
  logic rst_n;
  logic ce;
  sfrdc_req_t req;
  sfrdc_rsp_t rsp;
  sfrdc_cmp_sel_t neg_sel;
  sfrdc_cmp_sel_t pos_sel;
  logic [7:0] adc_sel;
  logic [7:0] page;
  logic [7:0] flags;
  int failures;
  int checks_done;
  int cycles;

  sfrdc_top dut_u (.ref_clk(ref_clk), .rst_n(rst_n), .ce(ce), .req(req),
    .rsp(rsp), .cmp1_negative_select(neg_sel),
    .cmp1_positive_select(pos_sel), .adc_channel_select(adc_sel),
    .register_page_select(page));
  assign flags = {5'h00, rsp.rvalid, rsp.ram_access, rsp.unmapped};

  task automatic final_report;
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : final_report

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp) begin
      failures++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask : chk

  // one request held for one edge; response is settled at the negedge
  task automatic acc(input logic r, input logic w, input logic b,
      input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    req <= '{rd: r, wr: w, bit_op: b, addr: a, wdata: d, bit_val: d[0]};
    @(posedge ref_clk);
    req <= '0;
    @(negedge ref_clk);
  endtask : acc

  task automatic rdc(input logic [7:0] a, input logic [7:0] exp);
    acc(1'b1, 1'b0, 1'b0, a, 8'h00);
    chk(rsp.rdata, exp);
  endtask : rdc

  task automatic settle;
    repeat (3) @(posedge ref_clk);
    @(negedge ref_clk);
  endtask : settle

  function automatic sfrdc_cmp_sel_t exp_sel(input logic neg,
      input logic [3:0] c);
    case (c)
      4'hC: return {1'b1, SRC_TOUCH, 4'h0};
      4'hD: return {1'b1, SRC_HALF_SUPPLY, 4'h0};
      4'hE: return {1'b1, neg ? SRC_DIG_SUPPLY : SRC_BAT_SUPPLY, 4'h0};
      4'hF: return {1'b1, neg ? SRC_GROUND : SRC_MAIN_SUPPLY, 4'h0};
      default: return (c[3] || (neg && c == 4'h7)) ? 8'h70
        : {1'b1, SRC_PIN, c[2], c[1:0], neg};
    endcase
  endfunction : exp_sel

  initial begin
    ref_clk = 1'b0;
    forever #25 ref_clk = ~ref_clk;
  end

  // cut a hang short well past the expected run length
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 5000) begin
      failures++;
      final_report;
    end
  end

  initial begin
    rst_n = 1'b0;
    ce = 1'b1;
    req = '0;
    repeat (4) @(posedge ref_clk);
    rst_n <= 1'b1;
    rdc(8'h9E, 8'hFF);
    rdc(8'hA7, 8'h00);
    rdc(8'hBB, 8'h00);
    chk(neg_sel, 8'hC0);
    chk(pos_sel, 8'hE0);
    chk(page, 8'h00);
    $display("test reset done");
    // routing probes stay on assigned offsets
    acc(1'b0, 1'b1, 1'b0, 8'h10, 8'h55);
    chk(flags, 8'h02);
    acc(1'b1, 1'b0, 1'b0, 8'h7F, 8'h00);
    chk(flags, 8'h02);
    acc(1'b1, 1'b0, 1'b0, 8'hA4, 8'h00);
    chk(flags, 8'h04);
    rdc(8'h90, 8'h00);
    $display("test routing done");
    for (int i = 0; i < 16; i++) begin
      acc(1'b0, 1'b1, 1'b0, 8'h9E, {i[3:0], i[3:0]});
      settle;
      chk(neg_sel, exp_sel(1'b1, i[3:0]));
      chk(pos_sel, exp_sel(1'b0, i[3:0]));
      rdc(8'h9E, {i[3:0], i[3:0]});
    end
    $display("test comparator done");
    acc(1'b0, 1'b1, 1'b0, 8'hA7, 8'h0F);
    chk(page, 8'h0F);
    acc(1'b0, 1'b1, 1'b0, 8'hA5, 8'h3C);
    rdc(8'hA5, 8'h3C);
    acc(1'b1, 1'b0, 1'b0, 8'h9E, 8'h00);
    chk(flags, 8'h05);
    acc(1'b0, 1'b1, 1'b0, 8'hA7, 8'h00);
    rdc(8'hA5, 8'h00);
    acc(1'b0, 1'b1, 1'b0, 8'hA7, 8'h01);
    acc(1'b1, 1'b0, 1'b0, 8'hA5, 8'h00);
    chk(flags, 8'h05);
    acc(1'b0, 1'b1, 1'b0, 8'hA7, 8'h00);
    $display("test paging done");
    acc(1'b0, 1'b1, 1'b1, 8'h93, 8'h01);
    rdc(8'h90, 8'h08);
    acc(1'b1, 1'b0, 1'b1, 8'h93, 8'h00);
    chk(rsp.rdata, 8'h01);
    acc(1'b0, 1'b1, 1'b1, 8'hA1, 8'h01);
    rdc(8'hA0, 8'h02);
    acc(1'b0, 1'b1, 1'b1, 8'h93, 8'h00);
    rdc(8'h90, 8'h00);
    $display("test bit access done");
    // pin 1.2 set up as analog input before channel select
    acc(1'b0, 1'b1, 1'b0, 8'hF2, 8'hFB);
    acc(1'b0, 1'b1, 1'b0, 8'hA5, 8'h00);
    acc(1'b0, 1'b1, 1'b1, 8'h92, 8'h01);
    acc(1'b0, 1'b1, 1'b0, 8'hD5, 8'h04);
    rdc(8'hF2, 8'hFB);
    rdc(8'hA5, 8'h00);
    rdc(8'h90, 8'h04);
    rdc(8'hD5, 8'h04);
    acc(1'b0, 1'b1, 1'b0, 8'hBB, 8'h5A);
    settle;
    chk(adc_sel, 8'h5A);
    rdc(8'hBB, 8'h5A);
    $display("test adc select done");
    // a request while the enable is low must be ignored
    @(posedge ref_clk);
    ce <= 1'b0;
    acc(1'b0, 1'b1, 1'b0, 8'hBB, 8'hA5);
    chk(flags, 8'h00);
    chk(adc_sel, 8'h5A);
    @(posedge ref_clk);
    ce <= 1'b1;
    rdc(8'hBB, 8'h5A);
    $display("test clock enable done");
    acc(1'b0, 1'b1, 1'b0, 8'h9E, 8'h12);
    @(posedge ref_clk);
    rst_n <= 1'b0;
    repeat (2) @(posedge ref_clk);
    rst_n <= 1'b1;
    rdc(8'hBB, 8'h00);
    rdc(8'h9E, 8'hFF);
    rdc(8'h90, 8'h00);
    chk(neg_sel, 8'hC0);
    chk(pos_sel, 8'hE0);
    $display("test second reset done");
    final_report;
  end
endmodule : sfrdc_tb_top
